// [core/hpc_regs.sv]
`timescale 1ns/1ps
module hpc_regs #(
	parameter int CONV_LIMIT = hpc_pkg::CONV_WAIT_CYC
) (
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  reset_n,
	// Register access from the serial engine
	input  wire hpc_pkg::hpc_byte_t    cmd_in,
	input  wire hpc_pkg::hpc_byte_t    wr_in,
	input  wire logic                  rd_strobe,
	output hpc_pkg::hpc_byte_t         rd_out,
	// Converter
	output logic                       conv_start,
	output hpc_pkg::hpc_conv_req_t     conv_req,
	input  wire hpc_pkg::hpc_byte_t    conv_done,
	// Slot A analog status and pins
	input  wire logic                  aux_good_a,
	input  wire logic                  main_good_a,
	input  wire logic                  override_input_a_n,
	output logic                       main_on_a,
	output logic                       aux_on_a,
	output logic                       power_good_pin_a_o,
	output logic                       power_good_pin_a_oe
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// Order: 2 override (idle high), 1 main good, 0 aux good
	localparam logic [2:0] SYNC_INIT = 3'h4;

	logic [2:0] raw_in;
	logic [2:0] sync1_reg;
	logic [2:0] sync2_reg;
	logic [2:0] sync3_reg;
	logic [2:0] filt_reg;

	assign raw_in = {override_input_a_n, main_good_a, aux_good_a};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_sync
			always_ff @(posedge clk or negedge reset_n)
			begin
				if (!reset_n)
				begin
					sync1_reg[gi] <= SYNC_INIT[gi];
					sync2_reg[gi] <= SYNC_INIT[gi];
					sync3_reg[gi] <= SYNC_INIT[gi];
					filt_reg[gi]  <= SYNC_INIT[gi];
				end
				else
				begin
					sync1_reg[gi] <= raw_in[gi];
					sync2_reg[gi] <= sync1_reg[gi];
					sync3_reg[gi] <= sync2_reg[gi];
					// Glitch of one cycle never reaches the flags
					if (sync2_reg[gi] == sync3_reg[gi])
						filt_reg[gi] <= sync3_reg[gi];
				end
			end
		end
	endgenerate

	wire aux_good_f  = filt_reg[0];
	wire main_good_f = filt_reg[1];
	wire ovr_low_f   = ~filt_reg[2];

	// ----------------------------------------------------------------
	// Address pointer
	// ----------------------------------------------------------------
	logic [7:0] pointer_reg;
	wire  [7:0] addr_eff  = cmd_in.valid ? cmd_in.data : pointer_reg;
	wire        addr_ok   = addr_eff <= hpc_pkg::ADDR_LAST;
	wire        wr_conv   = wr_in.valid && addr_ok && addr_eff == hpc_pkg::ADDR_CONV_CTRL;
	wire        wr_slot   = wr_in.valid && addr_ok && addr_eff == hpc_pkg::ADDR_SLOT_A;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			pointer_reg <= hpc_pkg::ADDR_RESULT;
		else if (cmd_in.valid)
			pointer_reg <= cmd_in.data;
	end

	// ----------------------------------------------------------------
	// Converter control
	// ----------------------------------------------------------------
	logic [4:0]                    conv_ctrl_reg;
	logic                          busy_reg;
	logic [7:0]                    result_reg;
	logic [hpc_pkg::CONV_CNT_W-1:0] wait_cnt_reg;

	localparam logic [hpc_pkg::CONV_CNT_W-1:0] WAIT_LAST =
		hpc_pkg::CONV_CNT_W'(CONV_LIMIT - 1);

	wire [2:0] sup_wr   = wr_in.data[2:0];
	wire       sup_ok   = sup_wr == hpc_pkg::SUP_3V3 || sup_wr == hpc_pkg::SUP_12V
		|| sup_wr == hpc_pkg::SUP_AUX;
	// Writes during a conversion would corrupt the running request
	wire       conv_wr  = wr_conv && !busy_reg;
	wire       start_go = conv_wr && sup_ok;
	wire       wait_end = busy_reg && wait_cnt_reg == WAIT_LAST;
	wire       done_now = busy_reg && conv_done.valid;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			conv_ctrl_reg <= hpc_pkg::CONV_CTRL_RST;
		else if (conv_wr)
			conv_ctrl_reg <= wr_in.data[4:0];
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			busy_reg <= 1'b0;
		else if (start_go)
			busy_reg <= 1'b1;
		else if (done_now || wait_end)
			busy_reg <= 1'b0;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			wait_cnt_reg <= '0;
		else if (!busy_reg)
			wait_cnt_reg <= '0;
		else
			wait_cnt_reg <= wait_cnt_reg + 1'b1;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			result_reg <= hpc_pkg::RESULT_RST;
		else if (done_now)
			result_reg <= conv_done.data;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			conv_start <= 1'b0;
			conv_req   <= '0;
		end
		else
		begin
			conv_start <= start_go;
			if (start_go)
			begin
				conv_req.slot_b          <= wr_in.data[hpc_pkg::BIT_SLOT_SEL];
				conv_req.quantity_choice <= wr_in.data[hpc_pkg::BIT_QUANTITY];
				conv_req.supply          <= sup_wr;
			end
		end
	end

	// ----------------------------------------------------------------
	// Slot A power control
	// ----------------------------------------------------------------
	logic [2:0] slot_a_reg;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			slot_a_reg <= hpc_pkg::SLOT_A_RST;
		else if (wr_slot)
			slot_a_reg <= wr_in.data[2:0];
	end

	wire override_act = ovr_low_f && !slot_a_reg[hpc_pkg::BIT_GATE];
	wire pg_drive     = aux_good_f && main_good_f && !override_act;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			main_on_a           <= 1'b0;
			aux_on_a            <= 1'b0;
			power_good_pin_a_o  <= 1'b0;
			power_good_pin_a_oe <= 1'b0;
		end
		else
		begin
			main_on_a           <= slot_a_reg[hpc_pkg::BIT_MAIN_ON];
			aux_on_a            <= slot_a_reg[hpc_pkg::BIT_AUX_ON];
			power_good_pin_a_o  <= 1'b0;
			power_good_pin_a_oe <= pg_drive;
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	function automatic logic [7:0] read_mux(input logic [7:0] a, input logic [7:0] res,
		input logic bsy, input logic [4:0] cc, input logic ag, input logic mg,
		input logic [2:0] sa);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			hpc_pkg::ADDR_RESULT:    v = res;
			hpc_pkg::ADDR_CONV_CTRL: v = {bsy, 2'b00, cc};
			hpc_pkg::ADDR_SLOT_A:    v = {ag, mg, 3'b000, sa};
			default:                 v = 8'h00;
		endcase
		return v;
	endfunction

	wire [7:0] rd_value = read_mux(addr_eff, result_reg, busy_reg, conv_ctrl_reg,
		aux_good_f, main_good_f, slot_a_reg);

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			rd_out <= '0;
		else
		begin
			rd_out.valid <= rd_strobe;
			if (rd_strobe)
				rd_out.data <= rd_value;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	AST_BUSY_START: assert property (
		start_go |=> busy_reg && conv_start ##1 !conv_start)
		else $error("conversion start not flagged");

	AST_REQ_FIELDS: assert property (
		start_go |=> conv_req.slot_b == $past(wr_in.data[4])
			&& conv_req.quantity_choice == $past(wr_in.data[3]))
		else $error("conversion request fields wrong");

	AST_NO_START_BAD: assert property (
		conv_wr && !sup_ok |=> !busy_reg && !conv_start)
		else $error("undefined supply started a conversion");

	AST_RESULT_DONE: assert property (
		done_now |=> !busy_reg && result_reg == $past(conv_done.data))
		else $error("result not valid as busy clears");

	AST_BUSY_READ: assert property (
		rd_strobe && addr_eff == hpc_pkg::ADDR_CONV_CTRL |=>
			rd_out.data[7] == $past(busy_reg) && rd_out.data[6:5] == 2'b00)
		else $error("busy bit or reserved bits misread");

	AST_SLOT_READ: assert property (
		rd_strobe && addr_eff == hpc_pkg::ADDR_SLOT_A |=>
			rd_out.data[7:6] == $past({aux_good_f, main_good_f})
			&& rd_out.data[5:3] == 3'b000)
		else $error("slot status misread");

	AST_MAIN_WRITE: assert property (
		wr_slot |=> ##1 main_on_a == $past(wr_in.data[1], 2)
			&& aux_on_a == $past(wr_in.data[0], 2))
		else $error("slot switches do not follow write");

	AST_FORCE_PIN: assert property (
		override_act |=> !power_good_pin_a_oe)
		else $error("pin driven good while override active");

	AST_PG_AND: assert property (
		!override_act |=> power_good_pin_a_oe == $past(aux_good_f && main_good_f))
		else $error("pin does not follow good bits");

	AST_RO_WRITE: assert property (
		wr_in.valid && addr_eff == hpc_pkg::ADDR_RESULT && !done_now |=> $stable(result_reg))
		else $error("write altered result register");

	AST_RESV_CMD: assert property (
		wr_in.valid && !addr_ok |=> $stable(slot_a_reg) && $stable(conv_ctrl_reg))
		else $error("reserved command wrote a register");

endmodule

// [core/hpc_pkg.sv]
package hpc_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_RESULT    = 8'h00;
	localparam logic [7:0] ADDR_CONV_CTRL = 8'h01;
	localparam logic [7:0] ADDR_SLOT_A    = 8'h02;
	localparam logic [7:0] ADDR_LAST      = 8'h07;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int         BIT_BUSY       = 7;
	localparam int         BIT_SLOT_SEL   = 4;
	localparam int         BIT_QUANTITY   = 3;
	localparam int         BIT_AUX_GOOD   = 7;
	localparam int         BIT_MAIN_GOOD  = 6;
	localparam int         BIT_GATE       = 2;
	localparam int         BIT_MAIN_ON    = 1;
	localparam int         BIT_AUX_ON     = 0;
	localparam logic [4:0] CONV_CTRL_RST  = 5'h00;
	localparam logic [2:0] SLOT_A_RST     = 3'h0;
	localparam logic [7:0] RESULT_RST     = 8'h00;

	// ----------------------------------------------------------------
	// Supply select codes
	// ----------------------------------------------------------------
	localparam logic [2:0] SUP_NONE       = 3'h0;
	localparam logic [2:0] SUP_3V3        = 3'h1;
	localparam logic [2:0] SUP_12V        = 3'h3;
	localparam logic [2:0] SUP_AUX        = 3'h5;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int         CLK_HZ         = 10_000_000;
	localparam int         CONV_WAIT_MS   = 100;
	localparam int         CONV_WAIT_CYC  = CONV_WAIT_MS * (CLK_HZ / 1000);
	localparam int         CONV_CNT_W     = 20;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       slot_b;
		logic       quantity_choice;
		logic [2:0] supply;
	} hpc_conv_req_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} hpc_byte_t;

endpackage

// [sim/hpc_conv_model.sv]
`timescale 1ns/1ps
module hpc_conv_model (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   reset_n,
	// Converter side
	input  wire logic                   conv_start,
	input  wire hpc_pkg::hpc_conv_req_t conv_req,
	input  wire logic [7:0]             lag,
	output hpc_pkg::hpc_byte_t          conv_done
);
	logic [7:0] cnt;

	// ----------------------------------------------------------------
	// Converter answer
	// ----------------------------------------------------------------
	// Lag 0 never answers, so the busy timeout can be reached.
	// result with done
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cnt       <= 8'h00;
			conv_done <= '0;
		end
		else
		begin
			conv_done.valid <= 1'b0;
			conv_done.data  <= ~conv_done.data;
			if (conv_start)
				cnt <= lag;
			else if (cnt != 8'h00)
				cnt <= cnt - 8'h01;
			if (cnt == 8'h01 && !conv_start)
			begin
				conv_done.valid <= 1'b1;
				conv_done.data  <= {3'h5, conv_req};
			end
		end
	end
endmodule

// [sim/test_adc_and_slot_a_control_regs.sv]
`timescale 1ns/1ps
module test_adc_and_slot_a_control_regs;
	logic                   clk                = 1'b0;
	logic                   reset_n            = 1'b0;
	hpc_pkg::hpc_byte_t     cmd_in             = '0;
	hpc_pkg::hpc_byte_t     wr_in              = '0;
	logic                   rd_strobe          = 1'b0;
	logic                   aux_good_a         = 1'b0;
	logic                   main_good_a        = 1'b0;
	logic                   override_input_a_n = 1'b1;
	logic [7:0]             lag                = 8'h03;
	hpc_pkg::hpc_byte_t     rd_out;
	hpc_pkg::hpc_byte_t     conv_done;
	hpc_pkg::hpc_conv_req_t conv_req;
	logic                   conv_start;
	logic                   main_on_a;
	logic                   aux_on_a;
	logic                   pg_o;
	logic                   pg_oe;
	int                     fails              = 0;
	int                     n_tests            = 0;
	logic [7:0]             d;

	always #50 clk = ~clk;

	hpc_regs #(.CONV_LIMIT(50)) i_hpc_regs (.clk(clk), .reset_n(reset_n), .cmd_in(cmd_in),
		.wr_in(wr_in), .rd_strobe(rd_strobe), .rd_out(rd_out), .conv_start(conv_start),
		.conv_req(conv_req), .conv_done(conv_done), .aux_good_a(aux_good_a),
		.main_good_a(main_good_a), .override_input_a_n(override_input_a_n),
		.main_on_a(main_on_a), .aux_on_a(aux_on_a), .power_good_pin_a_o(pg_o),
		.power_good_pin_a_oe(pg_oe));

	hpc_conv_model i_hpc_conv_model (.clk(clk), .reset_n(reset_n), .conv_start(conv_start),
		.conv_req(conv_req), .lag(lag), .conv_done(conv_done));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fails++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		cmd_in <= '{1'b1, a};
		wr_in  <= '{1'b1, v};
		@(posedge clk);
		cmd_in.valid <= 1'b0;
		wr_in.valid  <= 1'b0;
		#1;
	endtask

	// Raw read: leaves the byte in d, checks only that it was answered
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		cmd_in    <= '{1'b1, a};
		rd_strobe <= 1'b1;
		@(posedge clk);
		cmd_in.valid <= 1'b0;
		rd_strobe    <= 1'b0;
		#1;
		d = rd_out.data;
		check({7'h00, rd_out.valid}, 8'h01);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		rd(a);
		check(d, exp);
	endtask

	// Busy is polled under a bounded count; the result is then due.
	task automatic wait_idle();
		for (int i = 0; i < 40; i++)
		begin
			rd(8'h01);
			if (d[7] === 1'b0)
				break;
		end
		check({7'h00, d[7]}, 8'h00);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		rdc(8'h01, 8'h00);
		rdc(8'h02, 8'h00);
		check({6'h00, main_on_a, aux_on_a}, 8'h00);
		$display("t_reset done");
	endtask

	task automatic t_slot();
		logic [7:0] v[2] = '{8'h01, 8'h02};
		wr(8'h02, 8'hFF);
		rdc(8'h02, 8'h07);
		foreach (v[i])
		begin
			wr(8'h02, v[i]);
			rdc(8'h02, v[i]);
			check({6'h00, main_on_a, aux_on_a}, v[i]);
		end
		$display("t_slot done");
	endtask

	task automatic t_pgood();
		wr(8'h02, 8'h00);
		aux_good_a <= 1'b1;
		repeat (6) @(posedge clk);
		rdc(8'h02, 8'h80);
		check({7'h00, pg_oe}, 8'h00);
		main_good_a <= 1'b1;
		repeat (6) @(posedge clk);
		rdc(8'h02, 8'hC0);
		check({6'h00, pg_o, pg_oe}, 8'h01);
		override_input_a_n <= 1'b0;
		repeat (6) @(posedge clk);
		check({7'h00, pg_oe}, 8'h00);
		rdc(8'h02, 8'hC0);
		wr(8'h02, 8'h04);
		repeat (3) @(posedge clk);
		check({7'h00, pg_oe}, 8'h01);
		override_input_a_n <= 1'b1;
		$display("t_pgood done");
	endtask

	task automatic t_conv(input logic [4:0] c, input logic [7:0] l);
		lag <= l;
		wr(8'h01, {3'h0, c});
		check({7'h00, conv_start}, 8'h01);
		check({3'h0, conv_req}, {3'h0, c});
		rdc(8'h01, {3'h4, c});
		// A lag of one ends busy before this write would land
		if (l > 8'h01)
			wr(8'h01, 8'h0D);
		wait_idle();
		rdc(8'h01, {3'h0, c});
		rdc(8'h00, {3'h5, c});
		$display("t_conv done");
	endtask

	task automatic t_refuse();
		logic [2:0] bad[5] = '{3'h0, 3'h2, 3'h4, 3'h6, 3'h7};
		foreach (bad[i])
		begin
			wr(8'h01, {5'h02, bad[i]});
			check({7'h00, conv_start}, 8'h00);
			rdc(8'h01, {5'h02, bad[i]});
		end
		wr(8'h00, 8'h11);
		rdc(8'h00, 8'hBB);
		wr(8'h09, 8'hFF);
		rdc(8'h09, 8'h00);
		rdc(8'h02, 8'hC4);
		lag <= 8'h00;
		wr(8'h01, 8'h05);
		wait_idle();
		rdc(8'h00, 8'hBB);
		$display("t_refuse done");
	endtask

	// ----------------------------------------------------------------
	// Sequence and verdict
	// ----------------------------------------------------------------
	task automatic report_and_stop();
		$display("tests %0d fails %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial
	begin
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		t_reset();
		t_slot();
		t_pgood();
		t_conv(5'h09, 8'h03);
		t_conv(5'h13, 8'h28);
		t_conv(5'h05, 8'h01);
		t_conv(5'h1B, 8'h05);
		t_refuse();
		report_and_stop();
	end

	// Whole run needs a few hundred cycles at most.
	initial
	begin
		#2_000_000;
		fails++;
		report_and_stop();
	end
endmodule
